// >>> common/xcvr_pkg.sv
// Shared constants for the CAN transceiver mode and protection block.
// Assumes a 200 MHz core clock and a 32-bit APB register port.
package xcvr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ            = 200;
    // Mode settle time, dominant timeout and wake times in ns
    localparam int MODE_SETTLE_NS     = 20000;
    localparam int DOM_TIMEOUT_NS     = 1200000;
    localparam int WAKE_FILTER_NS     = 500;
    localparam int WAKE_TIMEOUT_NS    = 1800000;
    // Least times round up to whole cycles
    localparam int MODE_SETTLE_CYCLES      = (MODE_SETTLE_NS * CLK_MHZ + 999) / 1000;
    localparam int DOM_TIMEOUT_CYCLES_DEF  = (DOM_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_FILTER_CYCLES_DEF  = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
    // A longest time rounds down
    localparam int WAKE_TIMEOUT_CYCLES_DEF = (WAKE_TIMEOUT_NS * CLK_MHZ) / 1000;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam int          CTRL_TXALLOW_BIT = 0;
    localparam logic        CTRL_TXALLOW_RESET = 1'b1;
    localparam int          ST_MODE_LSB    = 0;
    localparam int          ST_DOMFAULT    = 4;
    localparam int          ST_OVERTEMP    = 5;
    localparam int          ST_MAINOK      = 6;
    localparam int          ST_IOOK        = 7;
    localparam int          ST_WAKESEEN    = 8;
    localparam int          ST_DRIVEON     = 9;

    // ------------------------------------------------------------
    // Bus bias codes and states
    // ------------------------------------------------------------
    localparam logic [1:0] BIAS_HIZ = 2'h0;
    localparam logic [1:0] BIAS_MID = 2'h1;
    localparam logic [1:0] BIAS_GND = 2'h2;

    typedef enum logic [3:0] {
        MODE_PROTECT = 4'h1,
        MODE_SETTLE  = 4'h2,
        MODE_NORMAL  = 4'h4,
        MODE_STANDBY = 4'h8
    } mode_e;

    typedef enum logic [3:0] {
        WAKE_IDLE = 4'h1,
        WAKE_DOM1 = 4'h2,
        WAKE_REC  = 4'h4,
        WAKE_DONE = 4'h8
    } wake_e;

endpackage

// >>> rtl/wake_pattern_filter.sv
// Low-power bus monitor: filters bus levels and spots the wake pattern.
// Assumes busDominantLp is the low-power receiver output, synchronous to clk.
`timescale 1ns/100ps

module wake_pattern_filter
    import xcvr_pkg::*;
#(
    parameter int FILTER_CYCLES  = WAKE_FILTER_CYCLES_DEF,
    parameter int TIMEOUT_CYCLES = WAKE_TIMEOUT_CYCLES_DEF
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic monitorEnable,
    input  wire logic busDominantLp,
    output logic      wakeRxOut,
    output logic      patternSeen
);

    localparam int FW = $clog2(FILTER_CYCLES + 1);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam logic [FW-1:0] FILT_LAST = FW'(FILTER_CYCLES - 1);
    localparam logic [TW-1:0] TO_LAST   = TW'(TIMEOUT_CYCLES - 1);

    logic          level_reg,    level_next;
    logic [FW-1:0] run_reg,      run_next;
    logic          filtered_reg, filtered_next;
    wake_e         wake_reg,     wake_next;
    logic [TW-1:0] toCount_reg,  toCount_next;
    logic          wakeRx_reg,   wakeRx_next;
    logic          filtEvent;
    logic          filtDom;
    logic          filtRec;

    // ------------------------------------------------------------
    // Level filter and pattern sequencer
    // ------------------------------------------------------------
    // A level counts as filtered once it has stood FILTER_CYCLES cycles
    always_comb begin
        level_next    = busDominantLp;
        run_next      = run_reg;
        filtered_next = filtered_reg;
        filtEvent     = 1'b0;
        if (busDominantLp != level_reg) begin
            run_next      = '0;
            filtered_next = 1'b0;
        end else if (!filtered_reg) begin
            if (run_reg == FILT_LAST) begin
                filtered_next = 1'b1;
                filtEvent     = 1'b1;
            end else begin
                run_next = run_reg + 1'b1;
            end
        end
        filtDom = filtEvent & busDominantLp;
        filtRec = filtEvent & ~busDominantLp;

        wake_next    = wake_reg;
        toCount_next = '0;
        // Timeout only runs while a pattern is half received
        if (wake_reg == WAKE_DOM1 || wake_reg == WAKE_REC) begin
            toCount_next = toCount_reg + 1'b1;
            if (toCount_reg == TO_LAST) begin
                wake_next    = WAKE_IDLE;
                toCount_next = '0;
            end
        end
        // Other bus traffic never resets the sequencer, only filtered levels advance it
        case (wake_reg)
            WAKE_IDLE: if (filtDom) wake_next = WAKE_DOM1;
            // A recessive on the last timeout cycle must not restart the window
            WAKE_DOM1: if (filtRec && toCount_reg != TO_LAST) wake_next = WAKE_REC;
            WAKE_REC:  if (filtDom) wake_next = WAKE_DONE;
            default:   wake_next = wake_reg;
        endcase
        if (!monitorEnable) begin
            wake_next    = WAKE_IDLE;
            toCount_next = '0;
        end
        // Receive line stays high until recognition, then low per filtered dominant
        wakeRx_next = !(wake_next == WAKE_DONE && filtered_next && busDominantLp);
    end

    // Register stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_reg    <= 1'b0;
            run_reg      <= '0;
            filtered_reg <= 1'b0;
            wake_reg     <= WAKE_IDLE;
            toCount_reg  <= '0;
            wakeRx_reg   <= 1'b1;
        end else begin
            level_reg    <= level_next;
            run_reg      <= run_next;
            filtered_reg <= filtered_next;
            wake_reg     <= wake_next;
            toCount_reg  <= toCount_next;
            wakeRx_reg   <= wakeRx_next;
        end
    end

    assign wakeRxOut   = wakeRx_reg;
    assign patternSeen = (wake_reg == WAKE_DONE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_recWait;
        wake_reg == WAKE_REC;
    endsequence

    a_wake_quiet_high: assert property (@(posedge clk) disable iff (!rst_n)
        !wakeRxOut |-> wake_reg == WAKE_DONE)
        else $error("receive line low before wake pattern");

    a_wake_timeout_reset: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_reg == WAKE_DOM1 && toCount_reg == TO_LAST) |=> wake_reg == WAKE_IDLE)
        else $error("wake timeout did not reset pattern logic");

    a_wake_order: assert property (@(posedge clk) disable iff (!rst_n)
        s_recWait ##1 (wake_reg == WAKE_DONE) |-> $past(filtDom))
        else $error("wake pattern completed without filtered dominant");

endmodule

// >>> rtl/can_xcvr_mode_protect.sv
// Mode and protection control of a high-speed CAN transceiver.
// Assumes supply monitors, thermal sensor and receivers give clean levels synchronous to clk.
`timescale 1ns/100ps

module can_xcvr_mode_protect
    import xcvr_pkg::*;
#(
    parameter int ADDR_W              = 12,
    parameter int DOM_TIMEOUT_CYCLES  = DOM_TIMEOUT_CYCLES_DEF,
    parameter int WAKE_TIMEOUT_CYCLES = WAKE_TIMEOUT_CYCLES_DEF,
    parameter int WAKE_FILTER_CYCLES  = WAKE_FILTER_CYCLES_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              txData,
    input  wire logic              txDataDriven,
    input  wire logic              standbySelect,
    input  wire logic              standbySelectDriven,
    input  wire logic              overTemp,
    input  wire logic              mainSupplyOk,
    input  wire logic              ioSupplyOk,
    input  wire logic              busDominant,
    input  wire logic              busDominantLp,
    output logic                   busDriveDominant,
    output logic      [1:0]        busBias,
    output logic                   rxOut,
    output logic                   rxOutOe_n
);

    localparam int DW = $clog2(DOM_TIMEOUT_CYCLES + 1);
    localparam int SW = $clog2(MODE_SETTLE_CYCLES + 1);
    localparam logic [DW-1:0] DOM_LAST    = DW'(DOM_TIMEOUT_CYCLES - 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(MODE_SETTLE_CYCLES - 1);

    // Address match used by both the write and the read decode
    function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        logic [ADDR_W-1:0] o;
        o      = ADDR_W'(off);
        regHit = (a[ADDR_W-1:2] == o[ADDR_W-1:2]);
    endfunction

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    logic txdEff;
    logic stbEff;
    // Weak pull-ups win when nothing drives the pin
    assign txdEff = txDataDriven ? txData : 1'b1;
    assign stbEff = standbySelectDriven ? standbySelect : 1'b1;

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    mode_e         mode_reg,   mode_next;
    logic [SW-1:0] settle_reg, settle_next;

    // An I/O supply fault takes priority over the standby select level; a main supply fault only when standby is not selected
    always_comb begin
        mode_next   = mode_reg;
        settle_next = '0;
        if (!ioSupplyOk || (!mainSupplyOk && !stbEff)) begin
            mode_next = MODE_PROTECT;
        end else if (stbEff) begin
            mode_next = MODE_STANDBY;
        end else begin
            case (mode_reg)
                MODE_SETTLE: begin
                    if (settle_reg == SETTLE_LAST) begin
                        mode_next = MODE_NORMAL;
                    end else begin
                        settle_next = settle_reg + 1'b1;
                    end
                end
                MODE_NORMAL: mode_next = MODE_NORMAL;
                default:     mode_next = MODE_SETTLE;
            endcase
        end
    end

    // Mode registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg   <= MODE_PROTECT;
            settle_reg <= '0;
        end else begin
            mode_reg   <= mode_next;
            settle_reg <= settle_next;
        end
    end

    logic isNormal;
    logic isStandby;
    assign isNormal  = (mode_reg == MODE_NORMAL);
    assign isStandby = (mode_reg == MODE_STANDBY);

    // ------------------------------------------------------------
    // Dominant timeout guard
    // ------------------------------------------------------------
    logic          txdPrev_reg,  txdPrev_next;
    logic          armed_reg,    armed_next;
    logic [DW-1:0] domCount_reg, domCount_next;
    logic          domFault_reg, domFault_next;

    // Only a falling edge arms the guard; a stuck-low level at mode entry does not
    always_comb begin
        txdPrev_next  = txdEff;
        armed_next    = armed_reg;
        domCount_next = domCount_reg;
        domFault_next = domFault_reg;
        if (!isNormal || txdEff) begin
            armed_next    = 1'b0;
            domCount_next = '0;
            domFault_next = 1'b0;
        end else if (txdPrev_reg) begin
            armed_next    = 1'b1;
            domCount_next = '0;
        end else if (armed_reg && !domFault_reg) begin
            if (domCount_reg == DOM_LAST) begin
                domFault_next = 1'b1;
            end else begin
                domCount_next = domCount_reg + 1'b1;
            end
        end
    end

    // Guard registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txdPrev_reg  <= 1'b1;
            armed_reg    <= 1'b0;
            domCount_reg <= '0;
            domFault_reg <= 1'b0;
        end else begin
            txdPrev_reg  <= txdPrev_next;
            armed_reg    <= armed_next;
            domCount_reg <= domCount_next;
            domFault_reg <= domFault_next;
        end
    end

    // ------------------------------------------------------------
    // Wake monitor
    // ------------------------------------------------------------
    logic wakeRx;
    logic wakeSeen;

    wake_pattern_filter #(
        .FILTER_CYCLES  (WAKE_FILTER_CYCLES),
        .TIMEOUT_CYCLES (WAKE_TIMEOUT_CYCLES)
    ) u_wake (
        .clk            (clk),
        .rst_n          (rst_n),
        .monitorEnable  (isStandby),
        .busDominantLp  (busDominantLp),
        .wakeRxOut      (wakeRx),
        .patternSeen    (wakeSeen)
    );

    // ------------------------------------------------------------
    // Registers on APB
    // ------------------------------------------------------------
    logic        txAllow_reg, txAllow_next;
    logic        ready_reg,   ready_next;
    logic [31:0] rdata_reg,   rdata_next;
    logic        err_reg,     err_next;
    logic [31:0] statusWord;

    assign statusWord = {22'h000000, busDriveDominant, wakeSeen, ioSupplyOk, mainSupplyOk,
                         overTemp, domFault_reg, mode_reg};

    // One wait state so read data leaves a flip-flop
    always_comb begin
        txAllow_next = txAllow_reg;
        ready_next   = 1'b0;
        rdata_next   = rdata_reg;
        err_next     = 1'b0;
        if (psel && penable && !ready_reg) begin
            ready_next = 1'b1;
            rdata_next = 32'h00000000;
            if (regHit(paddr, CTRL_OFFSET)) begin
                rdata_next = {31'h00000000, txAllow_reg};
            end else if (regHit(paddr, STATUS_OFFSET)) begin
                rdata_next = statusWord;
            end else begin
                err_next = 1'b1;
            end
        end
        // Write lands at the completing edge only
        if (psel && penable && ready_reg && pwrite && pstrb[0] && regHit(paddr, CTRL_OFFSET)) begin
            txAllow_next = pwdata[CTRL_TXALLOW_BIT];
        end
    end

    // Bus slave registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            txAllow_reg <= CTRL_TXALLOW_RESET;
            ready_reg   <= 1'b0;
            rdata_reg   <= 32'h00000000;
            err_reg     <= 1'b0;
        end else begin
            txAllow_reg <= txAllow_next;
            ready_reg   <= ready_next;
            rdata_reg   <= rdata_next;
            err_reg     <= err_next;
        end
    end

    assign pready  = ready_reg;
    assign prdata  = rdata_reg;
    assign pslverr = err_reg & ready_reg;

    // ------------------------------------------------------------
    // Bus and receive outputs
    // ------------------------------------------------------------
    logic       drive_reg, drive_next;
    logic [1:0] bias_reg,  bias_next;
    logic       rx_reg,    rx_next;
    logic       rxOe_reg,  rxOe_next;

    // Timeout and thermal faults cut the driver but leave bias and receive path alive
    always_comb begin
        drive_next = isNormal && !txdEff && !domFault_reg && !overTemp && txAllow_reg;
        bias_next  = BIAS_HIZ;
        rx_next    = 1'b1;
        if (isNormal) begin
            bias_next = BIAS_MID;
            rx_next   = !busDominant;
        end else if (isStandby) begin
            bias_next = BIAS_GND;
            rx_next   = wakeRx;
        end
        rxOe_next = !ioSupplyOk;
    end

    // Output registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_reg <= 1'b0;
            bias_reg  <= BIAS_HIZ;
            rx_reg    <= 1'b1;
            rxOe_reg  <= 1'b1;
        end else begin
            drive_reg <= drive_next;
            bias_reg  <= bias_next;
            rx_reg    <= rx_next;
            rxOe_reg  <= rxOe_next;
        end
    end

    assign busDriveDominant = drive_reg;
    assign busBias          = bias_reg;
    assign rxOut            = rx_reg;
    assign rxOutOe_n        = rxOe_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_settleDone;
        mode_reg == MODE_SETTLE && settle_reg == SETTLE_LAST;
    endsequence

    a_dom_release: assert property (@(posedge clk) disable iff (!rst_n)
        domFault_reg |=> !busDriveDominant)
        else $error("driver active during dominant timeout");

    a_dom_timing: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(domFault_reg) |-> $past(domCount_reg) == DOM_LAST && !$past(txdEff))
        else $error("dominant timeout fired at wrong count");

    a_dom_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (domFault_reg && txdEff) |=> !domFault_reg)
        else $error("timeout fault not cleared by recessive input");

    a_thermal_block: assert property (@(posedge clk) disable iff (!rst_n)
        overTemp |=> !busDriveDominant)
        else $error("driver active during over-temperature");

    a_rx_mirror: assert property (@(posedge clk) disable iff (!rst_n)
        isNormal |=> rxOut == !$past(busDominant) && busBias == BIAS_MID)
        else $error("receive output does not mirror bus in normal mode");

    a_drive_follow: assert property (@(posedge clk) disable iff (!rst_n)
        (isNormal && !txdEff && !domFault_reg && !overTemp && txAllow_reg) |=> busDriveDominant)
        else $error("driver not dominant for low transmit input");

    a_io_low_hiz: assert property (@(posedge clk) disable iff (!rst_n)
        !ioSupplyOk |=> (rxOutOe_n && mode_reg == MODE_PROTECT) ##1 busBias == BIAS_HIZ)
        else $error("outputs not released under I/O undervoltage");

    a_standby_bias: assert property (@(posedge clk) disable iff (!rst_n)
        (ioSupplyOk && stbEff) |=> isStandby ##1 busBias == BIAS_GND)
        else $error("standby select did not give ground bias");

    a_protect_rx: assert property (@(posedge clk) disable iff (!rst_n)
        (mode_reg == MODE_PROTECT && ioSupplyOk) |=> rxOut && !rxOutOe_n)
        else $error("receive output not recessive in protected state");

    a_settle_wait: assert property (@(posedge clk) disable iff (!rst_n)
        (isNormal && !$past(isNormal)) |-> $past(mode_reg == MODE_SETTLE && settle_reg == SETTLE_LAST))
        else $error("normal mode entered before settle time");

    a_settle_exit: assert property (@(posedge clk) disable iff (!rst_n)
        s_settleDone ##0 (ioSupplyOk && mainSupplyOk && !stbEff) |=> isNormal)
        else $error("normal mode not entered after settle time");

endmodule

// >>> testbench/can_ctrl_model.sv
// Protocol controller model on the transceiver logic pins.
// Assumes rxOut is a registered level on clk; the bench steers it by txReq and stbReq.
`timescale 1ns/100ps

module can_ctrl_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic txReq,
    input  wire logic stbReq,
    input  wire logic rxOut,
    output logic      txData,
    output logic      standbySelect
);
    logic rxPrev_reg;
    logic stbSeen_reg;

    // Low is dominant; the bench keeps dominant runs short, except one fault run
    assign txData = txReq;

    // Enter standby on request, leave it on the first falling receive edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxPrev_reg    <= 1'b1;
            stbSeen_reg   <= 1'b0;
            standbySelect <= 1'b0;
        end else begin
            rxPrev_reg  <= rxOut;
            stbSeen_reg <= stbReq;
            if (stbReq && !stbSeen_reg) begin
                standbySelect <= 1'b1;
            end else if (!stbReq || (rxPrev_reg && !rxOut)) begin
                standbySelect <= 1'b0;
            end
        end
    end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the transceiver mode and protection block.
// Assumes short sim values for the timeouts; settle time is the package figure.
`timescale 1ns/100ps

module tb;
    import xcvr_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, txReq = 1, stbReq = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic pready, pslverr, txData, txDataDriven = 1, standbySelect, standbySelectDriven = 1, er;
    logic overTemp = 0, mainSupplyOk = 1, ioSupplyOk = 1, busDominant = 0, busDominantLp = 0;
    logic busDriveDominant, rxOut, rxOutOe_n;
    logic [1:0] busBias;
    logic [31:0] r;
    int failCount = 0, checks = 0;

    always #2.5 clk = ~clk;

    can_xcvr_mode_protect #(.DOM_TIMEOUT_CYCLES(50), .WAKE_TIMEOUT_CYCLES(400), .WAKE_FILTER_CYCLES(4)) dut (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .txData(txData), .txDataDriven(txDataDriven), .standbySelect(standbySelect),
        .standbySelectDriven(standbySelectDriven), .overTemp(overTemp), .mainSupplyOk(mainSupplyOk),
        .ioSupplyOk(ioSupplyOk), .busDominant(busDominant), .busDominantLp(busDominantLp),
        .busDriveDominant(busDriveDominant), .busBias(busBias), .rxOut(rxOut), .rxOutOe_n(rxOutOe_n));

    can_ctrl_model ctrl (.clk(clk), .rst_n(rst_n), .txReq(txReq), .stbReq(stbReq), .rxOut(rxOut),
        .txData(txData), .standbySelect(standbySelect));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failCount++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task give_verdict;
        if (failCount == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #80000;
        failCount++;
        give_verdict;
    end

    initial begin
        void'($urandom(32'h262378b1));
        tick(4);
        rst_n <= 1'b1;
        tick(3000);
        apb(0, STATUS_OFFSET, 0);
        chk("mode settle", 32'h2, {28'h0, rd[3:0]});
        tick(1100);
        apb(0, STATUS_OFFSET, 0);
        chk("mode normal", 32'h4, {28'h0, rd[3:0]});
        apb(0, 12'h010, 0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // Random traffic both ways in normal mode
        repeat (30) begin
            tick(1);
            r = $urandom;
            txReq <= r[0];
            busDominant <= r[1];
            tick(2);
            #1;
            chk("drive", {31'h0, !r[0]}, {31'h0, busDriveDominant});
            chk("rx", {31'h0, !r[1]}, {31'h0, rxOut});
        end
        tick(1);
        txReq <= 1'b1; // A falling edge is needed to arm the guard
        busDominant <= 1'b0;
        tick(2);
        txReq <= 1'b0;
        tick(10);
        #1 chk("drive before timeout", 32'h1, {31'h0, busDriveDominant});
        tick(55);
        #1 chk("drive after timeout", 32'h0, {31'h0, busDriveDominant});
        apb(0, STATUS_OFFSET, 0);
        chk("timeout fault", 32'h1, {31'h0, rd[ST_DOMFAULT]});
        busDominant <= 1'b1;
        tick(3);
        #1 chk("rx in fault", 32'h0, {31'h0, rxOut});
        chk("bias in fault", {30'h0, BIAS_MID}, {30'h0, busBias});
        tick(1);
        txReq <= 1'b1;
        tick(3);
        txReq <= 1'b0;
        tick(3);
        #1 chk("drive restored", 32'h1, {31'h0, busDriveDominant});
        tick(1);
        txDataDriven <= 1'b0;
        tick(3);
        #1 chk("floating tx", 32'h0, {31'h0, busDriveDominant});
        tick(1);
        txDataDriven <= 1'b1;
        overTemp <= 1'b1;
        tick(3);
        #1 chk("hot drive", 32'h0, {31'h0, busDriveDominant});
        chk("hot rx", {29'h0, BIAS_MID, 1'b0}, {29'h0, busBias, rxOut});
        tick(1);
        overTemp <= 1'b0;
        tick(3);
        #1 chk("cool drive", 32'h1, {31'h0, busDriveDominant});
        // Clearing the transmit permission must cut the driver
        apb(1, CTRL_OFFSET, 32'h0);
        apb(0, CTRL_OFFSET, 32'h0);
        chk("ctrl readback", 32'h0, rd);
        #1 chk("drive gated", 32'h0, {31'h0, busDriveDominant});
        apb(1, CTRL_OFFSET, 32'h1);
        apb(0, CTRL_OFFSET, 32'h0);
        chk("ctrl restore", 32'h1, rd);
        tick(1);
        txReq <= 1'b1;
        busDominant <= 1'b0;
        mainSupplyOk <= 1'b0;
        standbySelectDriven <= 1'b0;
        stbReq <= 1'b1; // Model raises its pin before the pin is driven again
        tick(5);
        #1 chk("floating stb", {30'h0, BIAS_GND}, {30'h0, busBias});
        tick(1);
        standbySelectDriven <= 1'b1;
        tick(5);
        #1 chk("standby", {29'h0, BIAS_GND, 1'b1}, {29'h0, busBias, rxOut});
        chk("standby drive", 32'h0, {31'h0, busDriveDominant});
        // Stuck dominant: half a pattern, the wake timeout must clear it
        tick(1);
        busDominantLp <= 1'b1;
        tick(420);
        busDominantLp <= 1'b0;
        tick(10);
        #1 chk("wake timeout", 32'h3, {30'h0, standbySelect, rxOut});
        tick(1);
        busDominantLp <= 1'b1;
        tick(10);
        busDominantLp <= 1'b0;
        tick(10);
        #1 chk("no wake yet", 32'h1, {31'h0, standbySelect});
        busDominantLp <= 1'b1;
        tick(10);
        busDominantLp <= 1'b0;
        tick(5);
        #1 chk("woken", 32'h0, {31'h0, standbySelect});
        chk("protected", {29'h0, BIAS_HIZ, 1'b1}, {29'h0, busBias, rxOut});
        chk("protected oe", 32'h0, {31'h0, rxOutOe_n});
        tick(1);
        ioSupplyOk <= 1'b0;
        tick(4);
        #1 chk("io low", {29'h0, BIAS_HIZ, 1'b1}, {29'h0, busBias, rxOutOe_n});
        give_verdict;
    end
endmodule
